// file: core/pmd_bank.sv
// Purpose: peripheral disable register bank behind an APB slave
// Assumes: zero-wait access phase after a registered decode cycle
// Notes:   disable outputs double as the held reset of each peripheral

module pmd_bank
	import pmd_pkg::*;
#(
	parameter int ADDR_W   = PMD_ADDR_W,
	parameter int WAKE_CYC = PMD_FLASH_WAKE_CYC
) (
	input  wire logic              pclk,
	input  wire logic              presetn,
	input  wire logic              psel,
	input  wire logic              penable,
	input  wire logic              pwrite,
	input  wire logic [ADDR_W-1:0] paddr,
	input  wire logic [31:0]       pwdata,
	input  wire logic [3:0]        pstrb,
	output logic [31:0]            prdata,
	output logic                   pready,
	output logic                   pslverr,
	output logic                   periph_clock_gate,
	output logic                   vref_block_off,
	output logic                   flash_access_off,
	output logic                   clock_ref_out_off,
	output logic                   pin_change_irq_off,
	output logic [6:0]             timer_n_off,
	output logic                   num_osc_off,
	output logic                   dac_off,
	output logic                   adc_off,
	output logic                   comparator2_off,
	output logic                   comparator1_off,
	output logic                   zero_cross_off,
	output logic                   pwm7_off,
	output logic                   pwm6_off,
	output logic [4:0]             capcomp_n_off,
	output logic [2:0]             waveform_gen_n_off,
	output logic [1:0]             uart_n_off,
	output logic [1:0]             serial_port_n_off,
	output logic [1:0]             meas_timer_n_off,
	output logic [3:0]             logic_cell_n_off,
	output logic                   modulator_off,
	input  wire logic [5:0]        sfr_id,
	input  wire logic              sfr_wr_req,
	input  wire logic [7:0]        sfr_rd_data,
	output logic                   sfr_wr_go,
	output logic [7:0]             sfr_rd_data_out,
	input  wire logic              mem_rd_req,
	input  wire logic              mem_wr_req,
	input  wire logic              memctl_wr_req,
	input  wire logic              ind_hit,
	input  wire logic [7:0]        ind_rdata,
	output logic                   mem_rd_go,
	output logic                   mem_wr_go,
	output logic                   memctl_wr_go,
	output logic [7:0]             ind_rdata_out
);

	localparam logic [7:0] MASKS [PMD_NREG] = '{
		PMD_MASK0, PMD_MASK1, PMD_MASK2, PMD_MASK3,
		PMD_MASK4, PMD_MASK5, PMD_MASK6, PMD_MASK7
	};
	localparam int IDX_PAD = ADDR_W - 2 - PMD_IDX_W;

	logic [7:0]  ctl_q [PMD_NREG];
	logic [31:0] prdata_q;
	logic        pready_q;
	logic        pslverr_q;
	logic        sfr_wr_go_q;
	logic [7:0]  sfr_rd_data_q;
	logic        flash_ready;

	logic [PMD_IDX_W-1:0] word_idx;
	logic [PMD_IDX_W-1:0] ctl_off;
	logic                 aligned;
	logic                 hit_ctl;
	logic                 hit_stat;
	logic [2:0]           slot;
	logic                 setup_phase;
	logic                 write_take;
	logic [7:0]           stat_val;

	// disable bit that belongs to one peripheral register slot
	function automatic logic off_bit(input logic [5:0] id);
		logic [7:0] r;
		r = ctl_q[id[5:3]];
		return r[id[2:0]];
	endfunction

	assign word_idx    = paddr[PMD_IDX_W+1:2];
	assign ctl_off     = word_idx - PMD_CTL0_IDX;
	assign aligned     = (paddr[1:0] == 2'b00) && (paddr[ADDR_W-1:PMD_IDX_W+2] == IDX_PAD'(0));
	assign hit_ctl     = aligned && (word_idx >= PMD_CTL0_IDX) && (word_idx <= PMD_CTL7_IDX);
	assign hit_stat    = aligned && (word_idx == PMD_STAT_IDX);
	assign slot        = ctl_off[2:0];
	assign setup_phase = psel && !penable;
	// access phase lasts one cycle: pready is already high when it starts
	assign write_take  = psel && penable && pready_q && pwrite && pstrb[0];

	assign stat_val = {6'h00, periph_clock_gate, flash_ready};

	// one always_ff per register keeps each write path independent
	genvar gi;
	generate
		for (gi = 0; gi < PMD_NREG; gi++) begin : g_ctl
			always_ff @(posedge pclk or negedge presetn) begin
				if (!presetn)
					ctl_q[gi] <= PMD_CTL_RESET;
				else if (write_take && hit_ctl && slot == 3'(gi))
					ctl_q[gi] <= pwdata[7:0] & MASKS[gi];
			end
		end
	endgenerate

	// read data is captured in the setup cycle, so prdata is a flop
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			prdata_q  <= 32'h0000_0000;
			pready_q  <= 1'b0;
			pslverr_q <= 1'b0;
		end else begin
			pready_q  <= setup_phase;
			pslverr_q <= setup_phase && !(hit_ctl || hit_stat);
			if (setup_phase && !pwrite) begin
				if (hit_ctl)
					prdata_q <= {24'h00_0000, ctl_q[slot]};
				else if (hit_stat)
					prdata_q <= {24'h00_0000, stat_val};
				else
					prdata_q <= 32'h0000_0000;
			end
		end
	end

	assign prdata  = prdata_q;
	assign pready  = pready_q;
	assign pslverr = pslverr_q;

	// a set bit is the held reset of that block; clearing it restarts the block
	assign periph_clock_gate  = ctl_q[0][PMD_CLK_GATE_BIT];
	assign vref_block_off     = ctl_q[0][PMD_VREF_BIT];
	assign flash_access_off   = ctl_q[0][PMD_FLASH_BIT];
	assign clock_ref_out_off  = ctl_q[0][PMD_CLKREF_BIT];
	assign pin_change_irq_off = ctl_q[0][PMD_PINCHG_BIT];
	assign timer_n_off        = ctl_q[1][PMD_TIMER_LSB +: PMD_TIMER_N];
	assign num_osc_off        = ctl_q[2][PMD_NUMOSC_BIT];
	assign dac_off            = ctl_q[3][PMD_DAC_BIT];
	assign adc_off            = ctl_q[3][PMD_ADC_BIT];
	assign comparator2_off    = ctl_q[3][PMD_CMP2_BIT];
	assign comparator1_off    = ctl_q[3][PMD_CMP1_BIT];
	assign zero_cross_off     = ctl_q[3][PMD_ZCROSS_BIT];
	assign pwm7_off           = ctl_q[4][PMD_PWM7_BIT];
	assign pwm6_off           = ctl_q[4][PMD_PWM6_BIT];
	assign capcomp_n_off      = ctl_q[4][PMD_CAPCOMP_LSB +: PMD_CAPCOMP_N];
	assign waveform_gen_n_off = ctl_q[5][PMD_WAVEGEN_LSB +: PMD_WAVEGEN_N];
	assign uart_n_off         = ctl_q[6][PMD_UART_LSB +: 2];
	assign serial_port_n_off  = ctl_q[6][PMD_SERPORT_LSB +: 2];
	assign meas_timer_n_off   = ctl_q[7][PMD_MEASTMR_LSB +: 2];
	assign logic_cell_n_off   = ctl_q[7][PMD_LOGIC_LSB +: PMD_LOGIC_N];
	assign modulator_off      = ctl_q[7][PMD_MODULATOR_BIT];

	// peripheral register gate; no settle window is enforced after re-enable
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			sfr_wr_go_q   <= 1'b0;
			sfr_rd_data_q <= 8'h00;
		end else begin
			sfr_wr_go_q   <= sfr_wr_req && !off_bit(sfr_id);
			sfr_rd_data_q <= off_bit(sfr_id) ? 8'h00 : sfr_rd_data;
		end
	end

	assign sfr_wr_go       = sfr_wr_go_q;
	assign sfr_rd_data_out = sfr_rd_data_q;

	pmd_flash_gate #(
		.WAKE_CYC (WAKE_CYC)
	) u_flash_gate (
		.pclk           (pclk),
		.presetn        (presetn),
		.flash_off      (flash_access_off),
		.mem_rd_req     (mem_rd_req),
		.mem_wr_req     (mem_wr_req),
		.memctl_wr_req  (memctl_wr_req),
		.ind_hit        (ind_hit),
		.ind_rdata      (ind_rdata),
		.mem_rd_go_q    (mem_rd_go),
		.mem_wr_go_q    (mem_wr_go),
		.memctl_wr_go_q (memctl_wr_go),
		.ind_rdata_q    (ind_rdata_out),
		.flash_ready_q  (flash_ready)
	);

	a_apb_ready_next: assert property (@(posedge pclk) disable iff (!presetn)
		psel && !penable |=> pready && !$past(pready))
		else $error("pready not high in first access cycle");
	a_unmapped_error: assert property (@(posedge pclk) disable iff (!presetn)
		setup_phase && !hit_ctl && !hit_stat |=> pslverr && prdata == 32'h0000_0000
		|| pwrite)
		else $error("unmapped address without slave error");
	a_last_ctl_addr: assert property (@(posedge pclk) disable iff (!presetn)
		write_take && paddr == ADDR_W'({PMD_CTL7_IDX, 2'b00})
		|=> ctl_q[7] == ($past(pwdata[7:0]) & PMD_MASK7))
		else $error("last control register not at its address");
	a_clock_gate_write: assert property (@(posedge pclk) disable iff (!presetn)
		write_take && paddr == ADDR_W'({PMD_CTL0_IDX, 2'b00})
		|=> periph_clock_gate == $past(pwdata[PMD_CLK_GATE_BIT]))
		else $error("clock gate bit did not follow write");
	a_unimpl_zero: assert property (@(posedge pclk) disable iff (!presetn)
		write_take && hit_ctl && slot == 3'd5 |=> ctl_q[5][4:0] == 5'h00)
		else $error("unimplemented bits hold data");
	a_sfr_write_block: assert property (@(posedge pclk) disable iff (!presetn)
		sfr_wr_req && off_bit(sfr_id) |=> !sfr_wr_go)
		else $error("write reached a disabled peripheral");
	a_sfr_read_zero: assert property (@(posedge pclk) disable iff (!presetn)
		off_bit(sfr_id) |=> sfr_rd_data_out == 8'h00)
		else $error("disabled peripheral read not zero");
	a_sfr_read_pass: assert property (@(posedge pclk) disable iff (!presetn)
		!off_bit(sfr_id) |=> sfr_rd_data_out == $past(sfr_rd_data))
		else $error("enabled peripheral read altered");
	a_no_stray_write: assert property (@(posedge pclk) disable iff (!presetn)
		!write_take |=> $stable(ctl_q[3]) && $stable(ctl_q[0]))
		else $error("control register changed without a write");
	a_stat_readback: assert property (@(posedge pclk) disable iff (!presetn)
		setup_phase && !pwrite && hit_stat
		|=> prdata[PMD_STAT_CLK_GATED_BIT] == $past(periph_clock_gate)
		&& prdata[PMD_STAT_FLASH_READY_BIT] == $past(flash_ready))
		else $error("status read does not match state");

endmodule

// file: include/pmd_pkg.sv
// Purpose: shared constants and types for the peripheral disable bank
// Assumes: one pclk domain at 200 MHz, APB register access
// Notes:   register indices are scaled by four to form APB byte addresses
package pmd_pkg;

	localparam int PMD_NREG   = 8;
	localparam int PMD_ADDR_W = 16;
	localparam int PMD_IDX_W  = 12;

	// register indices; byte address is four times the index
	localparam logic [11:0] PMD_CTL0_IDX = 12'h796;
	localparam logic [11:0] PMD_CTL1_IDX = 12'h797;
	localparam logic [11:0] PMD_CTL2_IDX = 12'h798;
	localparam logic [11:0] PMD_CTL3_IDX = 12'h799;
	localparam logic [11:0] PMD_CTL4_IDX = 12'h79a;
	localparam logic [11:0] PMD_CTL5_IDX = 12'h79b;
	localparam logic [11:0] PMD_CTL6_IDX = 12'h79c;
	localparam logic [11:0] PMD_CTL7_IDX = 12'h79d;
	localparam logic [11:0] PMD_STAT_IDX = 12'h79e;

	localparam logic [7:0] PMD_CTL_RESET = 8'h00;

	// implemented bits of each control register
	localparam logic [7:0] PMD_MASK0 = 8'hc7;
	localparam logic [7:0] PMD_MASK1 = 8'h7f;
	localparam logic [7:0] PMD_MASK2 = 8'h80;
	localparam logic [7:0] PMD_MASK3 = 8'h67;
	localparam logic [7:0] PMD_MASK4 = 8'h7f;
	localparam logic [7:0] PMD_MASK5 = 8'he0;
	localparam logic [7:0] PMD_MASK6 = 8'h33;
	localparam logic [7:0] PMD_MASK7 = 8'h7f;

	// register 0 fields
	localparam int PMD_CLK_GATE_BIT = 7;
	localparam int PMD_VREF_BIT     = 6;
	localparam int PMD_FLASH_BIT    = 2;
	localparam int PMD_CLKREF_BIT   = 1;
	localparam int PMD_PINCHG_BIT   = 0;
	// registers 1 to 7 fields
	localparam int PMD_TIMER_LSB    = 0;
	localparam int PMD_TIMER_N      = 7;
	localparam int PMD_NUMOSC_BIT   = 7;
	localparam int PMD_DAC_BIT      = 6;
	localparam int PMD_ADC_BIT      = 5;
	localparam int PMD_CMP2_BIT     = 2;
	localparam int PMD_CMP1_BIT     = 1;
	localparam int PMD_ZCROSS_BIT   = 0;
	localparam int PMD_PWM7_BIT     = 6;
	localparam int PMD_PWM6_BIT     = 5;
	localparam int PMD_CAPCOMP_LSB  = 0;
	localparam int PMD_CAPCOMP_N    = 5;
	localparam int PMD_WAVEGEN_LSB  = 5;
	localparam int PMD_WAVEGEN_N    = 3;
	localparam int PMD_UART_LSB     = 4;
	localparam int PMD_SERPORT_LSB  = 0;
	localparam int PMD_MEASTMR_LSB  = 5;
	localparam int PMD_LOGIC_LSB    = 1;
	localparam int PMD_LOGIC_N      = 4;
	localparam int PMD_MODULATOR_BIT = 0;

	// status register fields
	localparam int PMD_STAT_FLASH_READY_BIT = 0;
	localparam int PMD_STAT_CLK_GATED_BIT   = 1;

	// flash wake time after re-enable
	localparam int PMD_CLK_PERIOD_NS   = 5;
	localparam int PMD_FLASH_WAKE_NS   = 1000;
	localparam int PMD_FLASH_WAKE_CYC  =
		(PMD_FLASH_WAKE_NS + PMD_CLK_PERIOD_NS - 1) / PMD_CLK_PERIOD_NS;

	typedef enum logic [1:0] {
		PMD_FL_OFF   = 2'b00,
		PMD_FL_WAIT  = 2'b01,
		PMD_FL_READY = 2'b11
	} pmd_flash_state_type;

endpackage

// file: core/pmd_flash_gate.sv
// Purpose: blocks flash traffic while flash access is disabled
// Assumes: request inputs are single-cycle strobes synchronous to pclk
// Notes:   every output is registered, so a request passes one cycle late
module pmd_flash_gate
	import pmd_pkg::*;
#(
	parameter int WAKE_CYC = PMD_FLASH_WAKE_CYC
) (
	input  wire logic       pclk,
	input  wire logic       presetn,
	input  wire logic       flash_off,
	input  wire logic       mem_rd_req,
	input  wire logic       mem_wr_req,
	input  wire logic       memctl_wr_req,
	input  wire logic       ind_hit,
	input  wire logic [7:0] ind_rdata,
	output logic            mem_rd_go_q,
	output logic            mem_wr_go_q,
	output logic            memctl_wr_go_q,
	output logic [7:0]      ind_rdata_q,
	output logic            flash_ready_q
);

	localparam int CNT_W   = $clog2(WAKE_CYC + 1);
	localparam int WAKE_HI = WAKE_CYC + 1;
	localparam logic [CNT_W-1:0] CNT_LAST = CNT_W'(WAKE_CYC - 1);

	pmd_flash_state_type state_q;
	pmd_flash_state_type state_d;
	logic [CNT_W-1:0]    cnt_q;

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			mem_rd_go_q    <= 1'b0;
			mem_wr_go_q    <= 1'b0;
			memctl_wr_go_q <= 1'b0;
			ind_rdata_q    <= 8'h00;
		end else begin
			mem_rd_go_q    <= mem_rd_req & ~flash_off;
			mem_wr_go_q    <= mem_wr_req & ~flash_off;
			memctl_wr_go_q <= memctl_wr_req & ~flash_off;
			ind_rdata_q    <= (flash_off && ind_hit) ? 8'h00 : ind_rdata;
		end
	end

	// ready is status only; software is expected to honour the wake time
	always_comb begin
		state_d = state_q;
		unique case (state_q)
			PMD_FL_OFF: begin
				if (!flash_off)
					state_d = PMD_FL_WAIT;
			end
			PMD_FL_WAIT: begin
				if (flash_off)
					state_d = PMD_FL_OFF;
				else if (cnt_q == CNT_LAST)
					state_d = PMD_FL_READY;
			end
			PMD_FL_READY: begin
				if (flash_off)
					state_d = PMD_FL_OFF;
			end
			default: state_d = PMD_FL_OFF;
		endcase
	end

	// starts in wait: the bank comes out of reset enabled
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			state_q       <= PMD_FL_WAIT;
			cnt_q         <= '0;
			flash_ready_q <= 1'b0;
		end else begin
			state_q       <= state_d;
			flash_ready_q <= (state_d == PMD_FL_READY);
			if (state_q == PMD_FL_WAIT && state_d == PMD_FL_WAIT)
				cnt_q <= cnt_q + 1'b1;
			else
				cnt_q <= '0;
		end
	end

	a_flash_rd_block: assert property (@(posedge pclk) disable iff (!presetn)
		(mem_rd_req || mem_wr_req || memctl_wr_req) && flash_off
		|=> !mem_rd_go_q && !mem_wr_go_q && !memctl_wr_go_q)
		else $error("flash request passed while disabled");
	a_ind_read_zero: assert property (@(posedge pclk) disable iff (!presetn)
		flash_off && ind_hit |=> ind_rdata_q == 8'h00)
		else $error("indirect read not zero while disabled");
	a_flash_ready_time: assert property (@(posedge pclk) disable iff (!presetn)
		$fell(flash_off) |-> ##[1:WAKE_HI] (flash_ready_q || flash_off))
		else $error("flash ready late after enable");
	a_ready_drops_off: assert property (@(posedge pclk) disable iff (!presetn)
		flash_off |=> !flash_ready_q)
		else $error("flash ready while disabled");

endmodule

// file: tb/tb_top.sv
// Purpose: self-checking bench for the peripheral disable bank
// Assumes: APB answers in its first access cycle; gates answer one cycle late
// Notes:   flash wake count shortened to WAKE cycles to keep the run brief
module tb_top
	import pmd_pkg::*;
;
	timeunit 1ns;
	timeprecision 1ps;

	localparam int          WAKE  = 4;
	localparam logic [15:0] STAT  = 16'h1e78;
	localparam logic [7:0]  MASKS [8] = '{PMD_MASK0, PMD_MASK1, PMD_MASK2, PMD_MASK3,
		PMD_MASK4, PMD_MASK5, PMD_MASK6, PMD_MASK7};

	logic        pclk, presetn, psel, penable, pwrite;
	logic [15:0] paddr;
	logic [31:0] pwdata, prdata, rd;
	logic [3:0]  pstrb;
	logic        pready, pslverr, e;
	logic        periph_clock_gate, vref_block_off, flash_access_off, clock_ref_out_off;
	logic        pin_change_irq_off, num_osc_off, dac_off, adc_off, comparator2_off;
	logic        comparator1_off, zero_cross_off, pwm7_off, pwm6_off, modulator_off;
	logic [6:0]  timer_n_off;
	logic [4:0]  capcomp_n_off;
	logic [2:0]  waveform_gen_n_off;
	logic [1:0]  uart_n_off, serial_port_n_off, meas_timer_n_off;
	logic [3:0]  logic_cell_n_off;
	logic [5:0]  sfr_id;
	logic        sfr_wr_req, sfr_wr_go, mem_rd_req, mem_wr_req, memctl_wr_req, ind_hit;
	logic        mem_rd_go, mem_wr_go, memctl_wr_go;
	logic [7:0]  sfr_rd_data, sfr_rd_data_out, ind_rdata, ind_rdata_out;
	logic [38:0] offs;
	logic [7:0]  sh [8];
	logic [7:0]  v;
	int          n_errors, checked, cycles;

	assign offs = {periph_clock_gate, vref_block_off, flash_access_off, clock_ref_out_off,
		pin_change_irq_off, timer_n_off, num_osc_off, dac_off, adc_off, comparator2_off,
		comparator1_off, zero_cross_off, pwm7_off, pwm6_off, capcomp_n_off, waveform_gen_n_off,
		uart_n_off, serial_port_n_off, meas_timer_n_off, logic_cell_n_off, modulator_off};

	pmd_bank #(.ADDR_W(16), .WAKE_CYC(WAKE)) u_pmd_bank (
		.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
		.paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata), .pready(pready),
		.pslverr(pslverr), .periph_clock_gate(periph_clock_gate),
		.vref_block_off(vref_block_off), .flash_access_off(flash_access_off),
		.clock_ref_out_off(clock_ref_out_off), .pin_change_irq_off(pin_change_irq_off),
		.timer_n_off(timer_n_off), .num_osc_off(num_osc_off), .dac_off(dac_off),
		.adc_off(adc_off), .comparator2_off(comparator2_off),
		.comparator1_off(comparator1_off), .zero_cross_off(zero_cross_off),
		.pwm7_off(pwm7_off), .pwm6_off(pwm6_off), .capcomp_n_off(capcomp_n_off),
		.waveform_gen_n_off(waveform_gen_n_off), .uart_n_off(uart_n_off),
		.serial_port_n_off(serial_port_n_off), .meas_timer_n_off(meas_timer_n_off),
		.logic_cell_n_off(logic_cell_n_off), .modulator_off(modulator_off),
		.sfr_id(sfr_id), .sfr_wr_req(sfr_wr_req), .sfr_rd_data(sfr_rd_data),
		.sfr_wr_go(sfr_wr_go), .sfr_rd_data_out(sfr_rd_data_out),
		.mem_rd_req(mem_rd_req), .mem_wr_req(mem_wr_req), .memctl_wr_req(memctl_wr_req),
		.ind_hit(ind_hit), .ind_rdata(ind_rdata), .mem_rd_go(mem_rd_go),
		.mem_wr_go(mem_wr_go), .memctl_wr_go(memctl_wr_go), .ind_rdata_out(ind_rdata_out)
	);

	always #2.5 pclk = ~pclk;

	task automatic final_report();
		$display("comparisons %0d, mismatches %0d", checked, n_errors);
		if (n_errors == 0 && checked > 0)
			$display("No errors found");
		else
			$display("Errors were found");
		$finish;
	endtask

	always @(posedge pclk) begin
		cycles++;
		if (cycles == 20000) begin
			n_errors++;
			$display("wrong value at %0t: run timed out", $time);
			final_report();
		end
	end

	task automatic chk(input logic [63:0] got, input logic [63:0] exp, input string what);
		checked++;
		if (got !== exp) begin
			n_errors++;
			$display("wrong value at %0t: %s got %h exp %h", $time, what, got, exp);
		end
	endtask

	task automatic chk_bit(input logic got, input logic exp, input string what);
		checked++;
		if (got !== exp) begin
			n_errors++;
			$display("wrong value at %0t: %s got %b exp %b", $time, what, got, exp);
		end
	endtask

	// request held from setup until the edge that samples pready high
	task automatic apb(input logic wr, input logic [15:0] a, input logic [7:0] d,
		input logic [3:0] st, output logic [31:0] rdat, output logic err);
		@(posedge pclk);
		psel    <= 1'b1;
		penable <= 1'b0;
		pwrite  <= wr;
		paddr   <= a;
		pwdata  <= {24'h000000, d};
		pstrb   <= st;
		@(posedge pclk);
		penable <= 1'b1;
		// no local limit: only the bench timeout ends a hung wait
		do begin
			@(posedge pclk);
		end while (pready !== 1'b1);
		rdat = prdata;
		err  = pslverr;
		psel    <= 1'b0;
		penable <= 1'b0;
		chk_bit(pready, 1'b1, "apb answer");
	endtask

	task automatic wreg(input logic [15:0] a, input logic [7:0] d, input logic exp_err);
		apb(1'b1, a, d, 4'hf, rd, e);
		chk_bit(e, exp_err, "write error flag");
	endtask

	task automatic rchk(input logic [15:0] a, input logic [31:0] exp, input logic exp_err);
		apb(1'b0, a, 8'h00, 4'h0, rd, e);
		chk(rd, exp, "read data");
		chk_bit(e, exp_err, "read error flag");
	endtask

	function automatic logic [15:0] addr_of(input int r);
		return 16'((int'(PMD_CTL0_IDX) + r) * 4);
	endfunction

	function automatic logic [38:0] exp_offs();
		return {sh[0][7:6], sh[0][2:0], sh[1][6:0], sh[2][7], sh[3][6:5], sh[3][2:0],
			sh[4][6:0], sh[5][7:5], sh[6][5:4], sh[6][1:0], sh[7][6:0]};
	endfunction

	task automatic check_all();
		for (int r = 0; r < 8; r++)
			rchk(addr_of(r), {24'h000000, sh[r]}, 1'b0);
		chk(offs, exp_offs(), "disable outputs");
	endtask

	task automatic sfr_probe(input logic [5:0] slot, input logic [7:0] d, input logic on);
		@(posedge pclk);
		sfr_id      <= slot;
		sfr_wr_req  <= 1'b1;
		sfr_rd_data <= d;
		@(posedge pclk);
		sfr_wr_req <= 1'b0;
		#1;
		chk_bit(sfr_wr_go, on, "peripheral write pass");
		chk(sfr_rd_data_out, on ? d : 8'h00, "peripheral read data");
	endtask

	task automatic mem_probe(input logic hit, input logic [7:0] d, input logic on);
		@(posedge pclk);
		{mem_rd_req, mem_wr_req, memctl_wr_req} <= 3'b111;
		ind_hit   <= hit;
		ind_rdata <= d;
		@(posedge pclk);
		{mem_rd_req, mem_wr_req, memctl_wr_req} <= 3'b000;
		#1;
		chk({mem_rd_go, mem_wr_go, memctl_wr_go}, {3{on}}, "memory pass");
		chk(ind_rdata_out, (on || !hit) ? d : 8'h00, "pointer read data");
	endtask

	initial begin
		pclk = 1'b0;
		presetn = 1'b0;
		{psel, penable, pwrite, sfr_wr_req, mem_rd_req, mem_wr_req} = '0;
		{memctl_wr_req, ind_hit} = '0;
		paddr = '0;
		pwdata = '0;
		pstrb = '0;
		sfr_id = '0;
		sfr_rd_data = '0;
		ind_rdata = '0;
		n_errors = 0;
		checked = 0;
		cycles = 0;
		repeat (6) @(posedge pclk);
		presetn <= 1'b1;
		foreach (sh[r]) sh[r] = 8'h00;
		check_all();
		$display("test reset_values done");
		for (int p = 0; p < 8; p++) begin
			v = (8'h55 << (p % 2)) & (p < 4 ? 8'hff : 8'h0f);
			for (int r = 0; r < 8; r++) begin
				sh[r] = v & MASKS[r];
				wreg(addr_of(r), v, 1'b0);
			end
			check_all();
		end
		// leave every block enabled so later tests start from a known state
		for (int r = 0; r < 8; r++) begin
			sh[r] = 8'h00;
			wreg(addr_of(r), 8'h00, 1'b0);
		end
		$display("test bit_map done");
		rchk(16'h1e54, 32'h0, 1'b1);
		rchk(16'h1e59, 32'h0, 1'b1);
		wreg(16'h1e7c, 8'hff, 1'b1);
		apb(1'b1, addr_of(1), 8'h7f, 4'he, rd, e);
		chk_bit(e, 1'b0, "masked strobe");
		rchk(addr_of(1), {24'h000000, sh[1]}, 1'b0);
		$display("test refused done");
		wreg(addr_of(1), 8'h08, 1'b0);
		sfr_probe(6'd11, 8'h5a, 1'b0);
		sfr_probe(6'd10, 8'h5a, 1'b1);
		wreg(addr_of(7), 8'h01, 1'b0);
		sfr_probe(6'd56, 8'h3c, 1'b0);
		wreg(addr_of(1), 8'h00, 1'b0);
		repeat (2) @(posedge pclk);
		sfr_probe(6'd11, 8'ha5, 1'b1);
		$display("test peripheral_gate done");
		wreg(addr_of(7), 8'h00, 1'b0);
		mem_probe(1'b1, 8'h3c, 1'b1);
		rchk(STAT, 32'h1, 1'b0);
		wreg(addr_of(0), 8'h84, 1'b0);
		mem_probe(1'b1, 8'h3c, 1'b0);
		mem_probe(1'b0, 8'h96, 1'b0);
		wreg(STAT, 8'h00, 1'b0);
		rchk(STAT, 32'h2, 1'b0);
		wreg(addr_of(0), 8'h00, 1'b0);
		rchk(STAT, 32'h0, 1'b0);
		repeat (WAKE + 2) @(posedge pclk);
		rchk(STAT, 32'h1, 1'b0);
		mem_probe(1'b1, 8'hc3, 1'b1);
		$display("test flash_gate done");
		for (int r = 0; r < 8; r++)
			wreg(addr_of(r), 8'hff, 1'b0);
		@(posedge pclk);
		presetn <= 1'b0;
		repeat (3) @(posedge pclk);
		presetn <= 1'b1;
		foreach (sh[r]) sh[r] = 8'h00;
		check_all();
		$display("test mid_reset done");
		final_report();
	end

endmodule
